// file: core/gpcmd_pkg.sv
package gpcmd_pkg;
   // ****************************************************************
   // Register map and field layout
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] CMD_OFFSET = 8'hA8;
   localparam logic [7:0] MODE_OFFSET = 8'hAC;
   localparam int CAL_LSB = 10;
   localparam int CAL_MSB = 12;
   localparam int SBA_BIT = 9;
   localparam int EN_BIT = 8;
   localparam int GT4G_BIT = 5;
   localparam int FW_BIT = 4;
   localparam int RATE_MSB = 2;
   localparam logic [31:0] CMD_RST_GEN2 = 32'h00000000;
   localparam logic [31:0] CMD_RST_GEN3 = 32'h00000A00;
   localparam logic [31:0] CMD_WR_MASK = 32'h00001F17;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************************************************************
   // Calibration period codes and times
   // ****************************************************************
   localparam logic [2:0] CAL_4MS = 3'h0;
   localparam logic [2:0] CAL_16MS = 3'h1;
   localparam logic [2:0] CAL_64MS = 3'h2;
   localparam logic [2:0] CAL_256MS = 3'h3;
   localparam logic [2:0] CAL_NONE = 3'h7;
   localparam int CLK_MHZ = 100;
   localparam int CAL_4MS_US = 4000;
   localparam int CAL_16MS_US = 16000;
   localparam int CAL_64MS_US = 64000;
   localparam int CAL_256MS_US = 256000;
   localparam int CAL_4MS_CYC = CAL_4MS_US * CLK_MHZ;
   localparam int CAL_16MS_CYC = CAL_16MS_US * CLK_MHZ;
   localparam int CAL_64MS_CYC = CAL_64MS_US * CLK_MHZ;
   localparam int CAL_256MS_CYC = CAL_256MS_US * CLK_MHZ;
   // ****************************************************************
   // Rate codes
   // ****************************************************************
   localparam logic [2:0] RATE_C0 = 3'h1;
   localparam logic [2:0] RATE_C1 = 3'h2;
   localparam logic [2:0] RATE_C2 = 3'h4;
   typedef enum logic [1:0] {GPCMD_RATE_NONE, GPCMD_RATE_1X, GPCMD_RATE_4X,
      GPCMD_RATE_8X} gpcmd_rate_t;
endpackage

// file: core/gpcmd_top.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Calibration code selects pulse period
// - Sideband enable bit ignored in gen3
// - Gen3 forces sideband addressing on
// - Port disabled ignores new operations, except the rest of a partial 1X sideband command
// - Accepted operations finish after disable
// - Partial 1X sideband command still issued
// - Pipe path needs enable, sideband also
// - Above-4GB enable reads zero always
// - Standard write without fast write or 1X
// - Fast write at selected rate
// - Gen2 rate decode 1X, 4X only
// - Gen3 rate decode 4X, 8X
// - Reset value depends on generation
// - Generation latched at power good
module gpcmd_top
   import gpcmd_pkg::*;
#(
   parameter int CAL_4MS_CYCLES = CAL_4MS_CYC,
   parameter int CAL_16MS_CYCLES = CAL_16MS_CYC,
   parameter int CAL_64MS_CYCLES = CAL_64MS_CYC,
   parameter int CAL_256MS_CYCLES = CAL_256MS_CYC
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   // Generation detect
   input wire logic power_good,
   input wire logic gen3_detect,
   // AXI4-Lite write address
   input wire logic [gpcmd_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [gpcmd_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Port request paths
   input wire logic pipe_req,
   input wire logic sba_req,
   input wire logic sba_cmd_start,
   input wire logic sba_cmd_last,
   input wire logic op_done,
   output logic pipe_accept,
   output logic sba_accept,
   output logic port_busy,
   // Port operating mode
   output logic sideband_active,
   output logic port_enable,
   output logic fast_write_active,
   output logic standard_write_active,
   output gpcmd_pkg::gpcmd_rate_t rate_mode,
   output logic rate_illegal,
   output logic cal_pulse
);
   import gpcmd_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   logic [31:0] cmd;
   logic gen3;
   logic pg_q;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [31:0] next_cmd;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_fire;
   logic [31:0] cal_cnt;
   logic [31:0] cal_limit;
   logic [3:0] outstanding;
   logic sba_partial;
   logic sideband_enable_eff;

   // ****************************************************************
   // Generation capture
   // ****************************************************************
   // Mode latched on rising power good, held afterwards
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pg_q <= 1'b0;
         gen3 <= 1'b0;
      end else if (clk_en) begin
         pg_q <= power_good;
         if (power_good && !pg_q) begin
            gen3 <= gen3_detect;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite write path
   // ****************************************************************
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;

   // Address and data captured independently, either order
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Response one cycle after both halves are held
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[ADDR_W-1:2] == CMD_OFFSET[ADDR_W-1:2]) ?
               RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Byte-lane merge of writable bits only
   always_comb begin
      next_cmd = cmd;
      for (int i = 0; i < 4; i++) begin
         if (w_strb[i]) begin
            next_cmd[i*8 +: 8] = w_data[i*8 +: 8];
         end
      end
      next_cmd = next_cmd & CMD_WR_MASK;
   end

   // Command register with generation dependent reset
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cmd <= CMD_RST_GEN2;
      end else if (clk_en) begin
         if (power_good && !pg_q) begin
            cmd <= gen3_detect ? CMD_RST_GEN3 : CMD_RST_GEN2;
         end else if (wr_fire && aw_addr[ADDR_W-1:2] == CMD_OFFSET[ADDR_W-1:2]) begin
            cmd <= next_cmd;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite read path
   // ****************************************************************
   assign s_axi_arready = !s_axi_rvalid;

   // Read decode, reserved and hardwired bits are zero
   always_comb begin
      rd_hit = 1'b1;
      rd_word = '0;
      if (s_axi_araddr[ADDR_W-1:2] == CMD_OFFSET[ADDR_W-1:2]) begin
         rd_word = cmd & CMD_WR_MASK;
      end else if (s_axi_araddr[ADDR_W-1:2] == MODE_OFFSET[ADDR_W-1:2]) begin
         rd_word = {28'h0000000, port_busy, sideband_enable_eff, rate_illegal, gen3};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Read data registered, held until taken
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Port control decode
   // ****************************************************************
   assign port_enable = cmd[EN_BIT];
   assign sideband_enable_eff = gen3 | cmd[SBA_BIT];
   assign sideband_active = sideband_enable_eff;

   // Rate decode per generation
   always_comb begin
      rate_illegal = 1'b0;
      case (cmd[RATE_MSB:0])
         RATE_C0: rate_mode = gen3 ? GPCMD_RATE_4X : GPCMD_RATE_1X;
         RATE_C1: begin
            rate_mode = gen3 ? GPCMD_RATE_8X : GPCMD_RATE_NONE;
            rate_illegal = !gen3;
         end
         RATE_C2: begin
            rate_mode = gen3 ? GPCMD_RATE_NONE : GPCMD_RATE_4X;
            rate_illegal = gen3;
         end
         default: begin
            rate_mode = GPCMD_RATE_NONE;
            rate_illegal = 1'b1;
         end
      endcase
   end

   // Fast write needs enable and a rate faster than 1X
   assign fast_write_active = cmd[FW_BIT] && (rate_mode == GPCMD_RATE_4X
      || rate_mode == GPCMD_RATE_8X);
   assign standard_write_active = !fast_write_active;

   // ****************************************************************
   // Request acceptance
   // ****************************************************************
   // New requests only while enabled, sideband also needs its enable
   assign pipe_accept = port_enable && pipe_req;
   assign sba_accept = sba_req && ((port_enable && sideband_enable_eff)
      || sba_partial);
   assign port_busy = (outstanding != 4'h0) || sba_partial;

   // Sideband command in flight at 1X rate survives a disable
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sba_partial <= 1'b0;
      end else if (clk_en) begin
         if (sba_accept && sba_cmd_start && !sba_cmd_last
            && rate_mode == GPCMD_RATE_1X) begin
            sba_partial <= 1'b1;
         end else if (sba_accept && sba_cmd_last) begin
            sba_partial <= 1'b0;
         end
      end
   end

   // Accepted operations counted until completed, regardless of enable
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         outstanding <= 4'h0;
      end else if (clk_en) begin
         outstanding <= 4'(outstanding
            + ((pipe_accept || (sba_accept && sba_cmd_last)) && outstanding != 4'hF)
            - (op_done && outstanding != 4'h0));
      end
   end

   // ****************************************************************
   // Calibration timer
   // ****************************************************************
   always_comb begin
      case (cmd[CAL_MSB:CAL_LSB])
         CAL_4MS: cal_limit = CAL_4MS_CYCLES;
         CAL_16MS: cal_limit = CAL_16MS_CYCLES;
         CAL_64MS: cal_limit = CAL_64MS_CYCLES;
         CAL_256MS: cal_limit = CAL_256MS_CYCLES;
         default: cal_limit = '0;
      endcase
   end

   // One-cycle pulse each period while port enabled, none when disabled or for no-calibration or reserved codes
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cal_cnt <= '0;
         cal_pulse <= 1'b0;
      end else if (clk_en) begin
         cal_pulse <= 1'b0;
         if (cal_limit == '0 || !port_enable) begin
            cal_cnt <= '0;
         end else if (cal_cnt >= cal_limit - 32'h1) begin
            cal_cnt <= '0;
            cal_pulse <= 1'b1;
         end else begin
            cal_cnt <= cal_cnt + 32'h1;
         end
      end
   end
endmodule

// file: verif/gpcmd_master_model.sv
`timescale 1ns/1ps
// ****
// Graphics master model
// ****
module gpcmd_master_model (
   // Clock and pace
   input wire logic clk_sys,
   input wire logic slow,
   // Answers from the target
   input wire logic pipe_accept,
   input wire logic sba_accept,
   // Requests
   output logic pipe_req = 1'h0,
   output logic sba_req = 1'h0,
   output logic sba_cmd_start = 1'h0,
   output logic sba_cmd_last = 1'h0,
   output logic op_done
);
   logic [15:0] done_sr = 16'h0000;
   // Completion follows each accepted operation after a fixed delay
   always @(posedge clk_sys) begin
      done_sr <= {done_sr[14:0], pipe_accept || (sba_accept && sba_cmd_last)};
   end
   assign op_done = slow ? done_sr[15] : done_sr[1];
   // One pipe request beat
   task automatic pipe_op(output logic acc);
      @(posedge clk_sys);
      pipe_req <= 1'h1;
      @(posedge clk_sys);
      acc = pipe_accept;
      pipe_req <= 1'h0;
   endtask
   // Sideband command of n beats, counting accepted beats
   task automatic sba_cmd(input int n, output int hits);
      hits = 0;
      @(posedge clk_sys);
      for (int i = 0; i < n; i++) begin
         sba_req <= 1'h1;
         sba_cmd_start <= (i == 0);
         sba_cmd_last <= (i == n - 1);
         @(posedge clk_sys);
         hits += int'(sba_accept);
      end
      sba_req <= 1'h0;
      sba_cmd_start <= 1'h0;
      sba_cmd_last <= 1'h0;
   endtask
endmodule

// file: verif/gpcmd_sva.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module gpcmd_sva
   import gpcmd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Port side
   input wire logic pipe_req,
   input wire logic pipe_accept,
   input wire logic sba_req,
   input wire logic sba_accept,
   input wire logic port_enable,
   input wire logic sideband_active,
   input wire logic fast_write_active,
   input wire logic standard_write_active,
   input gpcmd_pkg::gpcmd_rate_t rate_mode,
   input wire logic cal_pulse
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // Bus handshakes taken
   sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
   sequence s_wr_take; s_axi_bvalid && s_axi_bready; endsequence
   // Bus timing and refusal
   property p_rd_ans; s_rd_take |=> s_axi_rvalid; endproperty
   property p_rd_ref; s_axi_rvalid |-> !s_axi_arready; endproperty
   property p_wr_done; s_wr_take |=> !s_axi_bvalid; endproperty
   // Port acceptance, write mode and calibration pulse
   property p_pipe_on; pipe_req && port_enable |-> pipe_accept; endproperty
   property p_pipe_off; pipe_accept |-> pipe_req && port_enable; endproperty
   property p_sba_on; sba_req && port_enable && sideband_active |-> sba_accept; endproperty
   property p_std; rate_mode == GPCMD_RATE_1X |-> standard_write_active && !fast_write_active;
   endproperty
   property p_fw; fast_write_active |-> !standard_write_active && rate_mode != GPCMD_RATE_1X;
   endproperty
   property p_cal; cal_pulse |=> !cal_pulse [*3]; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   a_rd_ref: assert property (p_rd_ref) else $error("read taken while answering");
   a_wr_done: assert property (p_wr_done) else $error("write answer repeated");
   a_pipe_on: assert property (p_pipe_on) else $error("pipe request dropped");
   a_pipe_off: assert property (p_pipe_off) else $error("pipe taken while off");
   a_sba_on: assert property (p_sba_on) else $error("sideband request dropped");
   a_std: assert property (p_std) else $error("slow rate not standard");
   a_fw: assert property (p_fw) else $error("fast write at slow rate");
   a_cal: assert property (p_cal) else $error("calibration pulse too long");
endmodule
bind gpcmd_top gpcmd_sva u_sva (.*);

// file: verif/tb_graphics_port_command_register.sv
`timescale 1ns/1ps
// ****
// Register and port bench
// ****
module tb_graphics_port_command_register;
   import gpcmd_pkg::*;
   logic clk_sys, rst_b = 1'h0, clk_en = 1'h1, power_good = 1'h0, gen3_detect = 1'h0;
   logic slow = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, acc;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic pipe_req, sba_req, sba_cmd_start, sba_cmd_last, op_done, pipe_accept, sba_accept;
   logic port_busy, sideband_active, port_enable, fast_write_active, standard_write_active;
   logic rate_illegal, cal_pulse;
   gpcmd_rate_t rate_mode;
   gpcmd_rate_t g2[3] = '{GPCMD_RATE_1X, GPCMD_RATE_NONE, GPCMD_RATE_4X};
   gpcmd_rate_t g3[3] = '{GPCMD_RATE_4X, GPCMD_RATE_8X, GPCMD_RATE_NONE};
   int err_total = 0, tests_run = 0, hits, gap;
   gpcmd_top #(.CAL_4MS_CYCLES(10), .CAL_16MS_CYCLES(20), .CAL_64MS_CYCLES(30),
      .CAL_256MS_CYCLES(40)) dut (.*);
   gpcmd_master_model model (.*);
   // Free running clock
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Bus write, both channels offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         n++;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'h0;
      chk("bresp", s_axi_bresp, (a == CMD_OFFSET) ? RESP_OKAY : RESP_SLVERR);
      if (n >= 50) err_total++;
      if (n >= 50) stop_test();
   endtask
   // Bus read, masked compare of data and code
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         n++;
      end while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      chk("rresp", s_axi_rresp, (a == CMD_OFFSET || a == MODE_OFFSET) ? RESP_OKAY : RESP_SLVERR);
      chk("rdata", rd & m, e);
      if (n >= 50) err_total++;
      if (n >= 50) stop_test();
   endtask
   // Power good pulse with the given generation
   task automatic pg(input logic g);
      @(posedge clk_sys);
      power_good <= 1'h0;
      gen3_detect <= g;
      @(posedge clk_sys);
      power_good <= 1'h1;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic rates(input logic g);
      for (int i = 0; i < 3; i++) begin
         wr(CMD_OFFSET, 32'h00000110 | (32'h1 << i));
         chk("rate", rate_mode, g ? g3[i] : g2[i]);
         chk("illegal", rate_illegal, g ? (i == 2) : (i == 1));
      end
   endtask
   // Measures the second full gap between calibration pulses
   task automatic cal_gap(input logic [2:0] c, input int e);
      int n;
      wr(CMD_OFFSET, {19'h00000, c, 10'h100});
      for (n = 0; n < 100 && !cal_pulse; n++) @(posedge clk_sys);
      repeat (2) begin
         @(posedge clk_sys);
         for (gap = 1; gap < 100 && !cal_pulse; gap++) @(posedge clk_sys);
      end
      chk("cal", (n < 100) ? gap : 0, e);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'h1;
      pg(1'h0);
      rdchk(CMD_OFFSET, 32'hFFFFFFFF, 32'h00000000);
      rdchk(MODE_OFFSET, 32'h00000001, 32'h00000000);
      wr(CMD_OFFSET, 32'hFFFFFFFF);
      rdchk(CMD_OFFSET, 32'hFFFFFFFF, 32'h00001F17);
      rdchk(8'h10, 32'hFFFFFFFF, 32'h00000000);
      wr(8'h10, 32'h00000000);
      rdchk(CMD_OFFSET, 32'hFFFFFFFF, 32'h00001F17);
      rates(1'h0);
      chk("fw", fast_write_active, 1'h1);
      wr(CMD_OFFSET, 32'h00000111);
      chk("std", standard_write_active, 1'h1);
      wr(CMD_OFFSET, 32'h00000104);
      model.sba_cmd(2, hits);
      chk("sba off", hits, 0);
      model.pipe_op(acc);
      chk("pipe on", acc, 1'h1);
      wr(CMD_OFFSET, 32'h00000304);
      model.sba_cmd(2, hits);
      chk("sba on", hits, 2);
      wr(CMD_OFFSET, 32'h00000204);
      model.pipe_op(acc);
      chk("pipe off", acc, 1'h0);
      model.sba_cmd(2, hits);
      chk("sba off", hits, 0);
      wr(CMD_OFFSET, 32'h00000104);
      model.pipe_op(acc);
      wr(CMD_OFFSET, 32'h00000004);
      chk("busy", port_busy, 1'h1);
      repeat (20) @(posedge clk_sys);
      chk("idle", port_busy, 1'h0);
      wr(CMD_OFFSET, 32'h00000301);
      fork
         model.sba_cmd(6, hits);
         wr(CMD_OFFSET, 32'h00000000);
      join
      chk("sba 1x", hits, 6);
      repeat (20) @(posedge clk_sys);
      cal_gap(3'h0, 10);
      cal_gap(3'h1, 20);
      cal_gap(3'h2, 30);
      cal_gap(3'h3, 40);
      cal_gap(3'h4, 0);
      cal_gap(3'h7, 0);
      pg(1'h1);
      rdchk(CMD_OFFSET, 32'hFFFFFFFF, 32'h00000A00);
      rdchk(MODE_OFFSET, 32'h00000001, 32'h00000001);
      wr(CMD_OFFSET, 32'h00000100);
      chk("sba gen3", sideband_active, 1'h1);
      model.sba_cmd(2, hits);
      chk("sba gen3", hits, 2);
      rates(1'h1);
      stop_test();
   end
endmodule
